// ===== include/bcd_cfg.svh
// bus cycle definition constants: byte-enable codes, counts, reset values
`ifndef BCD_CFG_SVH
`define BCD_CFG_SVH

// ---------------------------------------------------------------------------
// special cycle byte-enable patterns (active low)
// ---------------------------------------------------------------------------
`define BCD_BE_SHUTDOWN 8'hFE
`define BCD_BE_FLUSH 8'hFD
`define BCD_BE_HALT_STOP 8'hFB
`define BCD_BE_WRITE_BACK 8'hF7
`define BCD_BE_FLUSH_ACK 8'hEF
`define BCD_BE_NONE 8'hFF

// ---------------------------------------------------------------------------
// transfer counts
// ---------------------------------------------------------------------------
`define BCD_BURST_BEATS 3'h4
`define BCD_SINGLE_BEATS 3'h1

// ---------------------------------------------------------------------------
// reset values of the cycle definition outputs
// ---------------------------------------------------------------------------
`define BCD_RST_DEF 6'h3E
`define BCD_RST_LOCK_N 1'h1

`endif

// ===== include/bcd_pkg.sv
// bus cycle definition types shared by the design and the bench
package bcd_pkg;

  // -------------------------------------------------------------------------
  // cycle kinds requested by the core
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    BCD_INT_ACK = 3'h0,
    BCD_SPECIAL = 3'h1,
    BCD_IO_READ = 3'h2,
    BCD_IO_WRITE = 3'h3,
    BCD_CODE_READ = 3'h4,
    BCD_DATA_READ = 3'h5,
    BCD_MEM_WRITE = 3'h6,
    BCD_BURST_WRITE = 3'h7
  } bcd_kind_t;

  typedef enum logic [2:0] {
    BCD_SP_SHUTDOWN = 3'h0,
    BCD_SP_FLUSH = 3'h1,
    BCD_SP_HALT = 3'h2,
    BCD_SP_WRITE_BACK = 3'h3,
    BCD_SP_FLUSH_ACK = 3'h4,
    BCD_SP_STOP_GRANT = 3'h5
  } bcd_special_t;

  // reason a cycle wants the bus locked
  typedef enum logic [2:0] {
    BCD_LK_NONE = 3'h0,
    BCD_LK_PREFIX = 3'h1,
    BCD_LK_DESCRIPTOR = 3'h2,
    BCD_LK_PAGE_TABLE = 3'h3,
    BCD_LK_INT_ACK = 3'h4,
    BCD_LK_EXCHANGE = 3'h5
  } bcd_lock_src_t;

  typedef struct packed {
    bcd_kind_t kind;
    bcd_special_t special;
    bcd_lock_src_t lockSrc;
    logic lockLast;
    logic cacheable;
    logic misaligned;
    logic [7:0] byteEnN;
  } bcd_req_t;

  // cycle definition as driven on the pins
  typedef struct packed {
    logic memoryOrIoN;
    logic dataOrControlN;
    logic writeOrReadN;
    logic lineFillCandidateN;
    logic atomicHoldN;
    logic misalignedSplit;
  } bcd_def_t;

endpackage

// ===== logic/bcd_cycle_def.sv
// bus cycle definition encoder, strobe sequencer, lock and bus hold control
//
// Summary of operation
// - every started cycle gets six-signal type code
// - type valid at strobe, held past next-address/last ready
// - lock held until last locked cycle's ready
// - type outputs float during bus hold
// - read candidate plus line fill enable: burst
// - write candidate only for write-back/replacement bursts
// - data_or_control high data, low control
// - lock for prefix, descriptor, page, ack, exchange
// - suppress bit: lock only page, interrupt ack
// - no bus hold while lock active
// - memory_or_io high memory, low io/ack/special
// - split flag only on misaligned locked cycles
// - write_or_read high writes/special, low reads/ack
// - special code and byte-enable meanings
// - halt/stop grant told apart by address bit four
// - code read encoding, cacheable shows candidate
// - data read encodings, locked and unlocked
// - memory write and io encodings
// - burst write candidate, lock kept after back-off
`include "bcd_cfg.svh"

module bcd_cycle_def (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reqValid,
  input wire bcd_pkg::bcd_req_t reqData,
  output logic reqReady,
  input wire logic lockSuppress,
  input wire logic busReleaseRequest,
  output logic busHoldAck,
  input wire logic nextAddressRequestN,
  input wire logic burstReadyN,
  input wire logic lineFillEnableN,
  input wire logic backOffN,
  output logic addressStrobeN,
  output logic memoryOrIoN,
  output logic dataOrControlN,
  output logic writeOrReadN,
  output logic lineFillCandidateN,
  output logic atomicHoldN,
  output logic misalignedSplit,
  output logic [7:0] byteEnablesN,
  output logic addrBitFour,
  output logic cycleDefOe,
  output logic cycleDone
);
  import bcd_pkg::*;

  // -------------------------------------------------------------------------
  // encoding functions
  // -------------------------------------------------------------------------
  function automatic logic lockWanted(input bcd_lock_src_t src, input logic suppress);
    logic want;
    want = 1'b0;
    unique case (src)
      BCD_LK_NONE: want = 1'b0;
      BCD_LK_PAGE_TABLE, BCD_LK_INT_ACK: want = 1'b1;
      BCD_LK_PREFIX, BCD_LK_DESCRIPTOR, BCD_LK_EXCHANGE: want = !suppress;
      default: want = 1'b0;
    endcase
    return want;
  endfunction

  // every branch lands on a listed cycle type, so no illegal code leaves
  function automatic bcd_def_t encodeDef(input bcd_req_t r, input logic locked,
                                         input logic keepLock);
    bcd_def_t d;
    d = bcd_def_t'(`BCD_RST_DEF);
    d.misalignedSplit = 1'b0;
    unique case (r.kind)
      BCD_INT_ACK: begin
        d = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      end
      BCD_SPECIAL: begin
        d = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      end
      BCD_IO_READ: begin
        d = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      end
      BCD_IO_WRITE: begin
        d = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      end
      BCD_CODE_READ: begin
        d = '{1'b1, 1'b0, 1'b0, !r.cacheable, 1'b1, 1'b0};
      end
      BCD_DATA_READ: begin
        if (locked) begin
          d = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, r.misaligned};
        end else begin
          d = '{1'b1, 1'b1, 1'b0, !r.cacheable, 1'b1, 1'b0};
        end
      end
      BCD_MEM_WRITE: begin
        d = '{1'b1, 1'b1, 1'b1, 1'b1, !locked, locked && r.misaligned};
      end
      BCD_BURST_WRITE: begin
        d = '{1'b1, 1'b1, 1'b1, 1'b0, !keepLock, 1'b0};
      end
    endcase
    return d;
  endfunction

  function automatic logic [7:0] specialBe(input bcd_special_t s);
    logic [7:0] be;
    be = `BCD_BE_NONE;
    unique case (s)
      BCD_SP_SHUTDOWN: be = `BCD_BE_SHUTDOWN;
      BCD_SP_FLUSH: be = `BCD_BE_FLUSH;
      BCD_SP_HALT, BCD_SP_STOP_GRANT: be = `BCD_BE_HALT_STOP;
      BCD_SP_WRITE_BACK: be = `BCD_BE_WRITE_BACK;
      BCD_SP_FLUSH_ACK: be = `BCD_BE_FLUSH_ACK;
      default: be = `BCD_BE_NONE;
    endcase
    return be;
  endfunction

  // -------------------------------------------------------------------------
  // sequencer states
  // -------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_HOLD = 4'b1000
  } bcd_state_t;

  bcd_state_t state_q, state_d;
  bcd_req_t cur_q;
  bcd_def_t def_q;
  logic locked_q;
  logic lockHeld_q;
  logic backoffLock_q;
  logic lockPinN_q;
  logic defFree_q;
  logic [2:0] beats_q;
  logic firstBeat_q;
  logic [7:0] be_q;
  logic bitFour_q;
  logic strobeN_q;
  logic oe_q;
  logic holdAck_q;
  logic done_q;

  logic start;
  logic lastReady;
  logic aborted;
  logic holdGo;
  logic reqLock;
  logic lockHeld_d;
  logic backoffLock_d;
  logic [2:0] beatsLeft;

  assign reqLock = (reqData.kind == BCD_INT_ACK) ||
                   (((reqData.kind == BCD_DATA_READ) || (reqData.kind == BCD_MEM_WRITE)) &&
                    lockWanted(reqData.lockSrc, lockSuppress));
  // bus hold only granted while no lock is standing
  assign holdGo = busReleaseRequest && !lockHeld_q && !backoffLock_q;
  assign start = (state_q == ST_IDLE) && reqValid && !holdGo;
  assign aborted = !backOffN && ((state_q == ST_ADDR) || (state_q == ST_DATA));
  // an unlocked cacheable read turns into a four-beat fill if the system allows it
  assign beatsLeft = (firstBeat_q && (cur_q.kind inside {BCD_CODE_READ, BCD_DATA_READ}) &&
                      !def_q.lineFillCandidateN && !lineFillEnableN) ?
                     `BCD_BURST_BEATS : beats_q;
  assign lastReady = (state_q == ST_DATA) && !burstReadyN && backOffN &&
                     (beatsLeft == `BCD_SINGLE_BEATS);

  // -------------------------------------------------------------------------
  // state transitions
  // -------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (holdGo) begin
          state_d = ST_HOLD;
        end else if (reqValid) begin
          state_d = ST_ADDR;
        end
      end
      ST_ADDR: state_d = aborted ? ST_IDLE : ST_DATA;
      ST_DATA: begin
        if (aborted || lastReady) begin
          state_d = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!busReleaseRequest) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // -------------------------------------------------------------------------
  // captured cycle and its encoding
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur_q <= '0;
      def_q <= bcd_def_t'(`BCD_RST_DEF);
      locked_q <= 1'b0;
      be_q <= `BCD_BE_NONE;
      bitFour_q <= 1'b0;
    end else if (ce && start) begin
      cur_q <= reqData;
      locked_q <= reqLock;
      def_q <= encodeDef(reqData, reqLock, backoffLock_q);
      if (reqData.kind == BCD_SPECIAL) begin
        be_q <= specialBe(reqData.special);
        bitFour_q <= (reqData.special == BCD_SP_STOP_GRANT);
      end else begin
        be_q <= reqData.byteEnN;
        bitFour_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // beat counting
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      beats_q <= `BCD_SINGLE_BEATS;
      firstBeat_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        beats_q <= (reqData.kind == BCD_BURST_WRITE) ? `BCD_BURST_BEATS : `BCD_SINGLE_BEATS;
        firstBeat_q <= 1'b1;
      end else if ((state_q == ST_DATA) && !burstReadyN && backOffN) begin
        beats_q <= beatsLeft - 3'h1;
        firstBeat_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // definition hold window: free from the clock after next-address or last ready
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      defFree_q <= 1'b1;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= lastReady;
      if (start) begin
        defFree_q <= 1'b0;
      end else if ((state_q == ST_DATA) && (!nextAddressRequestN || lastReady)) begin
        defFree_q <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // lock: held across a locked sequence and past a back-off abort
  // -------------------------------------------------------------------------
  always_comb begin
    lockHeld_d = lockHeld_q;
    backoffLock_d = backoffLock_q;
    if (start && reqLock) begin
      lockHeld_d = 1'b1;
    end else if (lastReady && locked_q && cur_q.lockLast) begin
      lockHeld_d = 1'b0;
    end
    // the write-back that follows an aborted locked cycle keeps the lock
    if (aborted && locked_q) begin
      backoffLock_d = 1'b1;
    end else if (lastReady && (cur_q.kind == BCD_BURST_WRITE)) begin
      backoffLock_d = 1'b0;
    end
  end

  // pin follows the next state so it falls with the strobe, from a flop
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lockHeld_q <= 1'b0;
      backoffLock_q <= 1'b0;
      lockPinN_q <= `BCD_RST_LOCK_N;
    end else if (ce) begin
      lockHeld_q <= lockHeld_d;
      backoffLock_q <= backoffLock_d;
      lockPinN_q <= !(lockHeld_d || backoffLock_d);
    end
  end

  // -------------------------------------------------------------------------
  // pins: strobe, enables, hold acknowledge
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strobeN_q <= 1'b1;
      oe_q <= 1'b1;
      holdAck_q <= 1'b0;
    end else if (ce) begin
      strobeN_q <= !start;
      oe_q <= (state_d != ST_HOLD);
      holdAck_q <= (state_d == ST_HOLD);
    end
  end

  assign reqReady = start && ce;
  assign addressStrobeN = strobeN_q;
  assign memoryOrIoN = def_q.memoryOrIoN;
  assign dataOrControlN = def_q.dataOrControlN;
  assign writeOrReadN = def_q.writeOrReadN;
  assign lineFillCandidateN = def_q.lineFillCandidateN;
  // lock pin follows the held lock, not just the current cycle
  assign atomicHoldN = lockPinN_q;
  assign misalignedSplit = def_q.misalignedSplit;
  assign byteEnablesN = be_q;
  assign addrBitFour = bitFour_q;
  assign cycleDefOe = oe_q;
  assign busHoldAck = holdAck_q;
  assign cycleDone = done_q;

  // defFree_q is kept for the hold window; values stay stable until next start
  logic unusedFree;
  assign unusedFree = defFree_q;

endmodule

// ===== verif/bcd_bus_model.sv
// far-side system bus responder: ready beats and line fill enable
module bcd_bus_model (
  input wire logic clk_sys,
  input wire logic addressStrobeN,
  input wire logic writeOrReadN,
  input wire logic lineFillCandidateN,
  input wire logic fillOn,
  input wire logic [1:0] waitCyc,
  output logic burstReadyN,
  output logic lineFillEnableN
);
  timeunit 1ns;
  timeprecision 100ps;
  int n;
  initial begin
    burstReadyN = 1'b1;
    lineFillEnableN = 1'b1;
    forever begin
      @(posedge clk_sys);
      #1;
      burstReadyN = 1'b1;
      lineFillEnableN = 1'b1;
      if (addressStrobeN === 1'b0) begin
        // write-back bursts take four beats whatever the enable
        n = (lineFillCandidateN === 1'b0 && (writeOrReadN === 1'b1 || fillOn)) ? 4 : 1;
        for (int i = 0; i < n; i++) begin
          repeat (waitCyc) begin
            @(posedge clk_sys);
            #1;
            burstReadyN = 1'b1;
            lineFillEnableN = 1'b1;
          end
          @(posedge clk_sys);
          #1;
          burstReadyN = 1'b0;
          lineFillEnableN = (i == 0) ? !fillOn : 1'b1;
        end
      end
    end
  end
endmodule

// ===== verif/bcd_cycle_def_assertions.sv
// checker of the cycle definition outputs of the bus cycle block
module bcd_cycle_def_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic addressStrobeN,
  input wire logic memoryOrIoN,
  input wire logic dataOrControlN,
  input wire logic writeOrReadN,
  input wire logic lineFillCandidateN,
  input wire logic atomicHoldN,
  input wire logic misalignedSplit,
  input wire logic [7:0] byteEnablesN,
  input wire logic addrBitFour,
  input wire logic cycleDefOe,
  input wire logic busHoldAck,
  input wire logic burstReadyN,
  input wire logic cycleDone
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic stb;
  assign stb = ~addressStrobeN;
  // ----
  // assertions
  // ----
  a_strobe_pulse: assert property ($fell(addressStrobeN) |=> addressStrobeN)
    else $error("strobe longer than one cycle");
  a_def_held: assert property (addressStrobeN |-> $stable({memoryOrIoN, dataOrControlN,
    writeOrReadN, lineFillCandidateN, misalignedSplit})) else $error("type changed");
  a_hold_float: assert property (busHoldAck |-> !cycleDefOe)
    else $error("type driven in hold");
  a_hold_unlocked: assert property (!atomicHoldN |-> !busHoldAck)
    else $error("hold taken under lock");
  a_special_code: assert property (stb && !memoryOrIoN && !dataOrControlN && writeOrReadN
    |-> lineFillCandidateN && atomicHoldN) else $error("bad special code");
  a_ack_locked: assert property (stb && !memoryOrIoN && !dataOrControlN && !writeOrReadN
    |-> !atomicHoldN && lineFillCandidateN) else $error("bad acknowledge code");
  a_io_plain: assert property (stb && !memoryOrIoN && dataOrControlN
    |-> lineFillCandidateN && atomicHoldN) else $error("bad io code");
  a_code_read: assert property (stb && memoryOrIoN && !dataOrControlN
    |-> !writeOrReadN && atomicHoldN) else $error("bad code read");
  a_locked_read: assert property (stb && !atomicHoldN && !writeOrReadN
    |-> lineFillCandidateN) else $error("locked read cacheable");
  a_split_locked: assert property (stb && misalignedSplit |-> !atomicHoldN)
    else $error("split on unlocked cycle");
  a_grant_marker: assert property (stb && addrBitFour
    |-> byteEnablesN == 8'hFB && !memoryOrIoN) else $error("bad stop grant");
  a_done_ready: assert property (cycleDone |-> $past(!burstReadyN))
    else $error("done without ready");
endmodule

bind bcd_cycle_def bcd_cycle_def_chk i_chk (.*);

// ===== verif/tb_bcd_cycle_def.sv
// testbench of the bus cycle definition block
module tb_bcd_cycle_def;
  timeunit 1ns;
  timeprecision 100ps;
  import bcd_pkg::*;
  logic clk_sys = 0, nrst = 0, reqValid = 0, lockSuppress = 0, busReleaseRequest = 0, fillOn = 0;
  logic [1:0] waitCyc = 0;
  logic backOffN = 1;
  bcd_req_t reqData = '0;
  logic reqReady, busHoldAck, burstReadyN, lineFillEnableN, addressStrobeN, memoryOrIoN;
  logic dataOrControlN, writeOrReadN, lineFillCandidateN, atomicHoldN, misalignedSplit;
  logic addrBitFour, cycleDefOe, cycleDone;
  logic [7:0] byteEnablesN;
  int num_errors = 0, n_tests = 0, cyc = 0;

  always #5 clk_sys = ~clk_sys;

  bcd_cycle_def i_dut (.ce(1'b1), .nextAddressRequestN(1'b1), .*);
  bcd_bus_model i_sys (.*);

  // ----
  // shared checks and transfers
  // ----
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function bcd_req_t mk(bcd_kind_t k, logic c, bcd_lock_src_t ls, logic last, logic m,
                        bcd_special_t sp = BCD_SP_SHUTDOWN);
    mk = '{k, sp, ls, last, c, m, 8'h0F};
  endfunction

  task run(input bcd_req_t r, input logic [4:0] e, input logic [7:0] nb, input logic [7:0] be);
    int k;
    logic [7:0] b;
    reqData = r;
    reqValid = 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (reqReady !== 1'b1 && k < 40);
    #1;
    reqValid = 1'b0;
    chk("strobe", {7'h0, addressStrobeN}, 8'h00);
    chk("type", {3'h0, memoryOrIoN, dataOrControlN, writeOrReadN, lineFillCandidateN,
        atomicHoldN}, {3'h0, e});
    chk("enables", byteEnablesN, be);
    chk("bit four", {7'h0, addrBitFour},
        {7'h0, r.kind == BCD_SPECIAL && r.special == BCD_SP_STOP_GRANT});
    if (!e[0]) chk("split", {7'h0, misalignedSplit}, {7'h0, r.misaligned});
    b = 0;
    k = 0;
    while (cycleDone !== 1'b1 && k < 40) begin
      @(posedge clk_sys);
      if (burstReadyN === 1'b0) b++;
      #1;
      k++;
    end
    chk("beats", b, nb);
    @(posedge clk_sys);
    #1;
    chk("lock after", {7'h0, atomicHoldN}, {7'h0, r.lockLast | e[0]});
  endtask

  // ----
  // scenarios
  // ----
  task t_kinds;
    fillOn = 1'b1;
    run(mk(BCD_CODE_READ, 1, BCD_LK_NONE, 0, 0), 5'b10001, 4, 8'h0F);
    fillOn = 1'b0;
    run(mk(BCD_CODE_READ, 1, BCD_LK_NONE, 0, 0), 5'b10001, 1, 8'h0F);
    run(mk(BCD_CODE_READ, 0, BCD_LK_NONE, 0, 0), 5'b10011, 1, 8'h0F);
    waitCyc = 2;
    run(mk(BCD_DATA_READ, 1, BCD_LK_NONE, 0, 0), 5'b11001, 1, 8'h0F);
    run(mk(BCD_DATA_READ, 0, BCD_LK_NONE, 0, 0), 5'b11011, 1, 8'h0F);
    run(mk(BCD_IO_READ, 0, BCD_LK_NONE, 0, 0), 5'b01011, 1, 8'h0F);
    run(mk(BCD_IO_WRITE, 0, BCD_LK_NONE, 0, 0), 5'b01111, 1, 8'h0F);
    run(mk(BCD_MEM_WRITE, 0, BCD_LK_NONE, 0, 0), 5'b11111, 1, 8'h0F);
    run(mk(BCD_BURST_WRITE, 0, BCD_LK_NONE, 0, 0), 5'b11101, 4, 8'h0F);
    waitCyc = 0;
    run(mk(BCD_INT_ACK, 0, BCD_LK_INT_ACK, 1, 0), 5'b00010, 1, 8'h0F);
  endtask

  task t_special;
    logic [7:0] be [6] = '{8'hFE, 8'hFD, 8'hFB, 8'hF7, 8'hEF, 8'hFB};
    for (int i = 0; i < 6; i++) begin
      run(mk(BCD_SPECIAL, 0, BCD_LK_NONE, 0, 0, bcd_special_t'(i)), 5'b00111, 1, be[i]);
    end
  endtask

  task t_lock_hold;
    run(mk(BCD_DATA_READ, 0, BCD_LK_PREFIX, 0, 1), 5'b11010, 1, 8'h0F);
    busReleaseRequest = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("hold in lock", {7'h0, busHoldAck}, 8'h00);
    run(mk(BCD_MEM_WRITE, 0, BCD_LK_EXCHANGE, 1, 0), 5'b11110, 1, 8'h0F);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("hold", {6'h0, busHoldAck, cycleDefOe}, 8'h02);
    reqValid = 1'b1;
    #1;
    chk("refused in hold", {7'h0, reqReady}, 8'h00);
    reqValid = 1'b0;
    busReleaseRequest = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("hold end", {6'h0, busHoldAck, cycleDefOe}, 8'h01);
    lockSuppress = 1'b1;
    run(mk(BCD_DATA_READ, 0, BCD_LK_DESCRIPTOR, 1, 0), 5'b11011, 1, 8'h0F);
    run(mk(BCD_MEM_WRITE, 0, BCD_LK_PAGE_TABLE, 1, 0), 5'b11110, 1, 8'h0F);
    lockSuppress = 1'b0;
  endtask

  // locked read aborted in its address cycle, then the write-back keeps the lock
  task t_backoff;
    reqData = mk(BCD_DATA_READ, 0, BCD_LK_PREFIX, 0, 0);
    reqValid = 1'b1;
    do @(posedge clk_sys); while (reqReady !== 1'b1);
    #1;
    reqValid = 1'b0;
    backOffN = 1'b0;
    @(posedge clk_sys);
    #1;
    backOffN = 1'b1;
    chk("lock on abort", {7'h0, atomicHoldN}, 8'h00);
    run(mk(BCD_BURST_WRITE, 0, BCD_LK_NONE, 0, 0), 5'b11100, 4, 8'h0F);
    run(mk(BCD_DATA_READ, 0, BCD_LK_PREFIX, 1, 0), 5'b11010, 1, 8'h0F);
  endtask

  // ----
  // sequence and hang guard
  // ----
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      wrap_up;
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    chk("reset", {cycleDefOe, addressStrobeN, memoryOrIoN, dataOrControlN, writeOrReadN,
        lineFillCandidateN, atomicHoldN, misalignedSplit}, 8'hFE);
    #1;
    nrst = 1'b1;
    t_kinds;
    t_special;
    t_lock_hold;
    t_backoff;
    wrap_up;
  end
endmodule
